// ### rtl/pif_regs.svh
`ifndef PIF_REGS_SVH
`define PIF_REGS_SVH

// register byte offsets
`define PIF_OFS_STATUS  12'h000
`define PIF_OFS_FILT    12'h004
`define PIF_OFS_FUNC0   12'h008
`define PIF_OFS_FUNC1   12'h00C
`define PIF_OFS_FUNC2   12'h010
`define PIF_OFS_CTRL    12'h014
`define PIF_OFS_FAULT   12'h018
`define PIF_OFS_MAXF    12'h01C
`define PIF_OFS_JOGF    12'h020
`define PIF_OFS_ACTION  12'h024

// control and fault bit positions
`define PIF_CTRL_TRIP_NC  0
`define PIF_CTRL_ILOCK    1
`define PIF_CTRL_UPDN_SAV 2
`define PIF_FAULT_EXT     0

// reset values
`define PIF_STATUS_RST  11'h000
`define PIF_FILT_RST    10'h00F
`define PIF_FUNC0_RST   32'h1B020100
`define PIF_FUNC1_RST   32'h1F1E1D1C
`define PIF_FUNC2_RST   32'h003F3F3F
`define PIF_CTRL_RST    3'h0
`define PIF_MAXF_RST    16'h1770
`define PIF_JOGF_RST    16'h03E8

// timing: filter time in ms, tick derived from the clock rate
`define PIF_FILT_MIN_MS 10'h002
`define PIF_FILT_MAX_MS 10'h3E8
`define PIF_CLK_HZ      40000000
`define PIF_TICK_MS     1
`define PIF_TICK_CYC    ((`PIF_CLK_HZ / 1000) * `PIF_TICK_MS)

`endif

// ### rtl/pif_pkg.sv
package pif_pkg;

    typedef enum logic [5:0] {
        PIF_SPD_L    = 6'h00,
        PIF_SPD_M    = 6'h01,
        PIF_SPD_H    = 6'h02,
        PIF_RMP_L    = 6'h03,
        PIF_RMP_M    = 6'h04,
        PIF_RMP_H    = 6'h05,
        PIF_DC_BRK   = 6'h06,
        PIF_SEC_FN   = 6'h07,
        PIF_EXCHG    = 6'h08,
        PIF_UP       = 6'h0A,
        PIF_DOWN     = 6'h0B,
        PIF_3WIRE    = 6'h0C,
        PIF_EXT_TRIP = 6'h0D,
        PIF_I_CLR    = 6'h0F,
        PIF_OPEN_LP  = 6'h10,
        PIF_LOCAL_REMOTE_SELECT  = 6'h11,
        PIF_ANA_HOLD = 6'h12,
        PIF_RMP_STOP = 6'h13,
        PIF_GAIN2    = 6'h14,
        PIF_ILOCK1   = 6'h16,
        PIF_ILOCK2   = 6'h17,
        PIF_ILOCK3   = 6'h18,
        PIF_ILOCK4   = 6'h19,
        PIF_SPD_X    = 6'h1A,
        PIF_RESET    = 6'h1B,
        PIF_ESTOP    = 6'h1C,
        PIF_JOG      = 6'h1D,
        PIF_FWD      = 6'h1E,
        PIF_REV      = 6'h1F,
        PIF_ANA_CHG  = 6'h20,
        PIF_PRE_EXC  = 6'h21,
        PIF_EXT_PID  = 6'h22,
        PIF_UPDN_CLR = 6'h23,
        PIF_NONE     = 6'h3F
    } pif_func_e;

endpackage

// ### rtl/pif_input_decoder.sv
// Local design decisions: the APB register port and the address map.
`timescale 1ns/1ps
`include "pif_regs.svh"

module pif_input_decoder #(
    parameter int NUM_IN    = 11,
    parameter int TICK_CYC  = `PIF_TICK_CYC
) (
    input  wire logic              core_clk,         // 40 MHz
    input  wire logic              rst_b,            // sync reset
    input  wire logic [NUM_IN-1:0] termIn,           // raw terminal pins
    input  wire logic              subBoardFitted,   // option board pin
    input  wire logic              driveStopped,     // from motor control
    input  wire logic              psel,             // apb select
    input  wire logic              penable,          // apb enable
    input  wire logic              pwrite,           // apb direction
    input  wire logic [11:0]       paddr,            // apb address
    input  wire logic [31:0]       pwdata,           // apb write data
    output logic      [31:0]       prdata,           // apb read data
    output logic                   pready,           // apb ready
    output logic                   pslverr,          // apb error
    output logic      [3:0]        speedIndex,       // preset step
    output logic                   jogSelect,        // jog active
    output logic      [15:0]       jogFreq,          // 0.01 Hz units
    output logic      [2:0]        rampIndex,        // ramp pair
    output logic                   dcBrakeOn,        // dc injection
    output logic                   secondFuncOn,     // 2nd functions
    output logic                   invLineOn,        // drive line out
    output logic                   commLineOn,       // commercial out
    output logic      [15:0]       upDnFreq,         // 0.01 Hz units
    output logic                   runFwd,           // forward run
    output logic                   runRev,           // reverse run
    output logic                   tripCutoff,       // fault latched
    output logic                   integratorClear,  // i-term zero
    output logic                   openLoop,         // v/f mode
    output logic                   remoteSelect,     // option/link source
    output logic                   freqHold,         // analog hold
    output logic                   rampStop,         // ramp halted
    output logic                   secondGainSel,    // p gain 2
    output logic      [3:0]        interlock,        // mmc interlocks
    output logic                   faultReset,       // fault reset
    output logic                   emergencyStop,    // stop, writes blocked
    output logic                   currentRefSel,    // i instead of v
    output logic                   preExcite,        // magnetizing
    output logic                   extPidRun         // external pid on
);
    logic [NUM_IN-1:0] sync1_ff, sync2_ff, subSync_ff;
    logic [NUM_IN-1:0] filt_ff;
    logic [9:0]        filtCnt_ff [NUM_IN];
    logic [15:0]       msCnt_ff;
    logic              msTick_ff;
    logic [9:0]        filtMs_ff;
    logic [5:0]        funcCode_ff [NUM_IN];
    logic [2:0]        ctrl_ff;
    logic [15:0]       maxFreq_ff;
    logic              subSync1_ff, subSync2_ff;
    logic [63:0]       funcOn, funcUsed;
    logic              tripLvl;
    logic [NUM_IN-1:0] lvl;
    logic              wrEn, setupCyc;
    logic [10:0]       status;
    logic [31:0]       rdVal;
    logic              rdOk;
    logic              threeWirePrev_ff, fwdPrev_ff, revPrev_ff;

    localparam logic [95:0] FUNC_RST = {`PIF_FUNC2_RST, `PIF_FUNC1_RST, `PIF_FUNC0_RST};

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    // two-stage sync of pins; first stage only feeds second
    always_ff @(posedge core_clk)
    begin
        sync1_ff    <= termIn;
        sync2_ff    <= sync1_ff;
        subSync1_ff <= subBoardFitted;
        subSync2_ff <= subSync1_ff;
    end

    // one millisecond tick
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            msCnt_ff  <= 16'h0000;
            msTick_ff <= 1'b0;
        end
        else if (msCnt_ff == 16'(TICK_CYC - 1))
        begin
            msCnt_ff  <= 16'h0000;
            msTick_ff <= 1'b1;
        end
        else
        begin
            msCnt_ff  <= msCnt_ff + 16'h0001;
            msTick_ff <= 1'b0;
        end
    end

    // per-input debounce, counted in whole ms so resolution is one tick
    for (genvar gi = 0; gi < NUM_IN; gi++)
    begin : g_filt
        always_ff @(posedge core_clk)
        begin
            if (!rst_b)
            begin
                filt_ff[gi]    <= 1'b0;
                filtCnt_ff[gi] <= 10'h000;
            end
            else if (sync2_ff[gi] == filt_ff[gi])
                filtCnt_ff[gi] <= 10'h000;
            else if (msTick_ff)
            begin
                // first tick after a change is partial, so one extra tick guarantees the full time
                if (filtCnt_ff[gi] >= filtMs_ff)
                begin
                    filt_ff[gi]    <= sync2_ff[gi];
                    filtCnt_ff[gi] <= 10'h000;
                end
                else
                    filtCnt_ff[gi] <= filtCnt_ff[gi] + 10'h001;
            end
        end
        filter_on_tick_a: assert property ($changed(filt_ff[gi]) |-> $past(msTick_ff))
            else $error("filtered level moved off a tick");
    end

    // optional inputs read off without the sub-board
    always_comb
    begin
        lvl = filt_ff;
        if (!subSync2_ff)
            lvl[NUM_IN-1:8] = '0;
    end
    assign status = lvl[10:0];

    // function decode; interlock overrides the first four inputs
    always_comb
    begin
        logic [5:0] code;
        code     = 6'h00;
        funcOn   = '0;
        funcUsed = '0;
        tripLvl  = 1'b0;
        for (int i = 0; i < NUM_IN; i++)
        begin
            code = funcCode_ff[i];
            if (ctrl_ff[`PIF_CTRL_ILOCK] && i < 4)
                code = 6'(pif_pkg::PIF_ILOCK1 + i);
            funcUsed[code] = 1'b1;
            if (lvl[i])
                funcOn[code] = 1'b1;
            if (code == pif_pkg::PIF_EXT_TRIP && (lvl[i] ^ ctrl_ff[`PIF_CTRL_TRIP_NC]))
                tripLvl = 1'b1;
        end
    end

    // level-type actions
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            speedIndex <= 4'h0;
            jogSelect <= 1'b0;
            rampIndex <= 3'h0;
            dcBrakeOn <= 1'b0;
            secondFuncOn <= 1'b0;
            invLineOn <= 1'b1;
            commLineOn <= 1'b0;
            integratorClear <= 1'b0;
            remoteSelect <= 1'b0;
            freqHold <= 1'b0;
            rampStop <= 1'b0;
            secondGainSel <= 1'b0;
            interlock <= 4'h0;
            faultReset <= 1'b0;
            emergencyStop <= 1'b0;
            currentRefSel <= 1'b0;
            extPidRun <= 1'b0;
        end
        else
        begin
            jogSelect <= funcOn[pif_pkg::PIF_JOG];
            if (funcOn[pif_pkg::PIF_JOG])
                speedIndex <= 4'h0;
            else
                speedIndex <= {funcOn[pif_pkg::PIF_SPD_X], funcOn[pif_pkg::PIF_SPD_H],
                               funcOn[pif_pkg::PIF_SPD_M], funcOn[pif_pkg::PIF_SPD_L]};
            rampIndex <= {funcOn[pif_pkg::PIF_RMP_H], funcOn[pif_pkg::PIF_RMP_M],
                          funcOn[pif_pkg::PIF_RMP_L]};
            dcBrakeOn <= funcOn[pif_pkg::PIF_DC_BRK] & driveStopped;
            secondFuncOn <= funcOn[pif_pkg::PIF_SEC_FN];
            commLineOn <= funcOn[pif_pkg::PIF_EXCHG];
            invLineOn <= ~funcOn[pif_pkg::PIF_EXCHG];
            integratorClear <= funcOn[pif_pkg::PIF_I_CLR];
            remoteSelect <= funcOn[pif_pkg::PIF_LOCAL_REMOTE_SELECT];
            freqHold <= funcOn[pif_pkg::PIF_ANA_HOLD];
            rampStop <= funcOn[pif_pkg::PIF_RMP_STOP];
            secondGainSel <= funcOn[pif_pkg::PIF_GAIN2];
            interlock <= funcOn[pif_pkg::PIF_ILOCK4:pif_pkg::PIF_ILOCK1];
            faultReset <= funcOn[pif_pkg::PIF_RESET];
            emergencyStop <= funcOn[pif_pkg::PIF_ESTOP];
            currentRefSel <= funcOn[pif_pkg::PIF_ANA_CHG];
            extPidRun <= funcOn[pif_pkg::PIF_EXT_PID];
        end
    end

    jog_masks_speed_a: assert property (jogSelect |-> speedIndex == 4'h0)
        else $error("speed index not masked by jog");
    dc_injection_request_stop_a: assert property (dcBrakeOn |-> $past(driveStopped))
        else $error("dc braking while running");
    line_exclusive_a: assert property (invLineOn != commLineOn)
        else $error("both line outputs equal");
    iclear_follows_a: assert property ($rose(funcOn[pif_pkg::PIF_I_CLR]) |=> integratorClear)
        else $error("integrator clear did not follow input");

    // mode switch only taken while stopped
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            openLoop <= 1'b0;
        else if (driveStopped)
            openLoop <= funcOn[pif_pkg::PIF_OPEN_LP];
    end
    open_loop_stop_a: assert property ($changed(openLoop) |-> $past(driveStopped))
        else $error("control mode changed while running");

    // run commands; three-wire latches pulses, three-wire input low stops
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            runFwd <= 1'b0;
            runRev <= 1'b0;
            fwdPrev_ff <= 1'b0;
            revPrev_ff <= 1'b0;
            threeWirePrev_ff <= 1'b0;
        end
        else
        begin
            fwdPrev_ff <= funcOn[pif_pkg::PIF_FWD];
            revPrev_ff <= funcOn[pif_pkg::PIF_REV];
            threeWirePrev_ff <= funcOn[pif_pkg::PIF_3WIRE];
            if (emergencyStop)
            begin
                runFwd <= 1'b0;
                runRev <= 1'b0;
            end
            else if (funcUsed[pif_pkg::PIF_3WIRE])
            begin
                if (!funcOn[pif_pkg::PIF_3WIRE])
                begin
                    runFwd <= 1'b0;
                    runRev <= 1'b0;
                end
                else if (funcOn[pif_pkg::PIF_FWD] && !fwdPrev_ff)
                begin
                    runFwd <= 1'b1;
                    runRev <= 1'b0;
                end
                else if (funcOn[pif_pkg::PIF_REV] && !revPrev_ff)
                begin
                    runFwd <= 1'b0;
                    runRev <= 1'b1;
                end
            end
            else
            begin
                runFwd <= funcOn[pif_pkg::PIF_FWD] & ~funcOn[pif_pkg::PIF_REV];
                runRev <= funcOn[pif_pkg::PIF_REV] & ~funcOn[pif_pkg::PIF_FWD];
            end
        end
    end
    estop_stops_a: assert property (emergencyStop |=> !runFwd && !runRev)
        else $error("run held under emergency stop");

    // pre-excitation leaves on a run command
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            preExcite <= 1'b0;
        else if (runFwd || runRev)
            preExcite <= 1'b0;
        else if (funcOn[pif_pkg::PIF_PRE_EXC])
            preExcite <= 1'b1;
    end

    // external trip latch; a new trip wins over any clear
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            tripCutoff <= 1'b0;
        else if (tripLvl)
            tripCutoff <= 1'b1;
        else if (faultReset)
            tripCutoff <= 1'b0;
        else if (wrEn && paddr == `PIF_OFS_FAULT && pwdata[`PIF_FAULT_EXT])
            tripCutoff <= 1'b0;
    end
    trip_latch_a: assert property (tripLvl |=> tripCutoff [*2])
        else $error("external trip not latched");

    // up/down speed, one 0.01 Hz step per ms
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            upDnFreq <= 16'h0000;
        else if (funcOn[pif_pkg::PIF_UPDN_CLR] && ctrl_ff[`PIF_CTRL_UPDN_SAV])
            upDnFreq <= 16'h0000;
        else if (upDnFreq > maxFreq_ff)
            upDnFreq <= maxFreq_ff;
        else if (msTick_ff && funcOn[pif_pkg::PIF_UP] && !funcOn[pif_pkg::PIF_DOWN])
        begin
            if (upDnFreq < maxFreq_ff)
                upDnFreq <= upDnFreq + 16'h0001;
        end
        else if (msTick_ff && funcOn[pif_pkg::PIF_DOWN] && !funcOn[pif_pkg::PIF_UP])
        begin
            if (upDnFreq != 16'h0000)
                upDnFreq <= upDnFreq - 16'h0001;
        end
    end
    updn_clamp_a: assert property ($past(upDnFreq) <= $past(maxFreq_ff) |-> upDnFreq <= maxFreq_ff)
        else $error("up/down frequency above maximum");

    // apb slave, zero wait: pready rises in the access cycle
    assign setupCyc = psel & ~penable;
    assign wrEn     = psel & penable & pready & pwrite & ~pslverr;

    always_comb
    begin
        rdOk  = 1'b1;
        rdVal = 32'h0000_0000;
        if (paddr == `PIF_OFS_STATUS)
            rdVal[10:0] = status;
        else if (paddr == `PIF_OFS_FILT)
            rdVal[9:0] = filtMs_ff;
        else if (paddr == `PIF_OFS_FUNC0 || paddr == `PIF_OFS_FUNC1 || paddr == `PIF_OFS_FUNC2)
        begin
            for (int i = 0; i < NUM_IN; i++)
                if (paddr == `PIF_OFS_FUNC0 + 12'(4 * (i / 4)))
                    rdVal[8 * (i % 4) +: 6] = funcCode_ff[i];
        end
        else if (paddr == `PIF_OFS_CTRL)
            rdVal[2:0] = ctrl_ff;
        else if (paddr == `PIF_OFS_FAULT)
            rdVal[`PIF_FAULT_EXT] = tripCutoff;
        else if (paddr == `PIF_OFS_MAXF)
            rdVal[15:0] = maxFreq_ff;
        else if (paddr == `PIF_OFS_JOGF)
            rdVal[15:0] = jogFreq;
        else if (paddr == `PIF_OFS_ACTION)
            rdVal[19:0] = {openLoop, preExcite, runRev, runFwd, emergencyStop,
                           dcBrakeOn, commLineOn, jogSelect, rampIndex, speedIndex, interlock};
        else
            rdOk = 1'b0;
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else
        begin
            pready  <= setupCyc;
            // writes refused while emergency stop holds
            pslverr <= setupCyc & (~rdOk | (pwrite & emergencyStop));
            prdata  <= (setupCyc & ~pwrite) ? rdVal : 32'h0000_0000;
        end
    end
    apb_ready_a: assert property (setupCyc |=> pready ##1 !pready) // zero-wait access
        else $error("pready not one access cycle");
    estop_blocks_a: assert property (setupCyc && pwrite && emergencyStop |=> pslverr)
        else $error("write accepted under emergency stop");

    // configuration registers; filter time clamped into its range
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            filtMs_ff  <= `PIF_FILT_RST;
            ctrl_ff    <= `PIF_CTRL_RST;
            maxFreq_ff <= `PIF_MAXF_RST;
            jogFreq    <= `PIF_JOGF_RST;
            for (int i = 0; i < NUM_IN; i++)
                funcCode_ff[i] <= FUNC_RST[8 * i +: 6];
        end
        else if (wrEn)
        begin
            if (paddr == `PIF_OFS_FILT)
            begin
                if (pwdata[31:10] != 22'h0 || pwdata[9:0] > `PIF_FILT_MAX_MS)
                    filtMs_ff <= `PIF_FILT_MAX_MS;
                else if (pwdata[9:0] < `PIF_FILT_MIN_MS)
                    filtMs_ff <= `PIF_FILT_MIN_MS;
                else
                    filtMs_ff <= pwdata[9:0];
            end
            else if (paddr == `PIF_OFS_CTRL)
                ctrl_ff <= pwdata[2:0];
            else if (paddr == `PIF_OFS_MAXF)
                maxFreq_ff <= pwdata[15:0];
            else if (paddr == `PIF_OFS_JOGF)
                jogFreq <= pwdata[15:0];
            else
            begin
                for (int i = 0; i < NUM_IN; i++)
                    if (paddr == `PIF_OFS_FUNC0 + 12'(4 * (i / 4)))
                        funcCode_ff[i] <= pwdata[8 * (i % 4) +: 6];
            end
        end
    end
    filt_range_a: assert property (filtMs_ff >= `PIF_FILT_MIN_MS && filtMs_ff <= `PIF_FILT_MAX_MS)
        else $error("filter time out of range");

endmodule // pif_input_decoder

// ### sim/pif_contacts.sv
`timescale 1ns/1ps
module pif_contacts (
    input  wire logic        core_clk, // bench clock
    input  wire logic [10:0] want,     // requested contacts
    input  wire logic        bounce,   // commanded chatter
    output logic      [10:0] termIn    // terminal levels
);
    logic flip;
    // chatter never holds one level long enough to pass a filter
    always_ff @(posedge core_clk)
        flip <= bounce ? ~flip : 1'b0;
    assign termIn = want ^ {11{flip}};
endmodule // pif_contacts

// ### sim/programmable_input_function_decoder_test.sv
`timescale 1ns/1ps
`include "pif_regs.svh"
module programmable_input_function_decoder_test;
    logic        core_clk = 0;
    logic        rst_b = 0;
    logic        psel = 0;
    logic        penable = 0;
    logic        pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0;
    logic        subBoardFitted = 0;
    logic        driveStopped = 1;
    logic [10:0] want = 0;
    logic        bounce = 0;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, err;
    logic [10:0] termIn;
    logic [15:0] jogFreq, upDnFreq;
    logic [3:0]  speedIndex, interlock;
    logic [2:0]  rampIndex;
    logic        jogSelect, dcBrakeOn, secondFuncOn, invLineOn, commLineOn, runFwd;
    logic        runRev, tripCutoff, integratorClear, openLoop, remoteSelect, freqHold;
    logic        rampStop, secondGainSel, faultReset, emergencyStop, currentRefSel;
    logic        preExcite, extPidRun;
    logic [9:0]  lvl;
    logic [5:0]  codes [9] = '{6'h0F, 6'h11, 6'h12, 6'h13, 6'h14, 6'h20, 6'h22, 6'h06, 6'h08};
    logic [9:0]  expLvl [9] = '{10'h200, 10'h100, 10'h080, 10'h040, 10'h020, 10'h010,
                                10'h008, 10'h004, 10'h003};
    int          fails = 0;
    int          total_checks = 0;
    assign lvl = {integratorClear, remoteSelect, freqHold, rampStop, secondGainSel,
                  currentRefSel, extPidRun, dcBrakeOn, commLineOn, ~invLineOn};
    always #12.5 core_clk = ~core_clk;
    pif_input_decoder #(.TICK_CYC(4)) DUT (.*);
    pif_contacts PARTNER (.core_clk(core_clk), .want(want), .bounce(bounce), .termIn(termIn));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (n == 50)
            fails++;
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge core_clk);
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(0, a, 0);
        chk(rd, exp);
    endtask
    // filter of 2 ms at 4-cycle ticks plus sync settles well inside 40 cycles
    task automatic settle(input logic [10:0] p);
        want <= p;
        repeat (40) @(posedge core_clk);
    endtask
    task automatic report_and_stop;
        $display("checks=%0d fails=%0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge core_clk);
        fails++;
        report_and_stop();
    end
    initial
    begin
        repeat (6) @(posedge core_clk);
        rst_b <= 1;
        @(posedge core_clk);
        chk(jogFreq, `PIF_JOGF_RST);
        chk(invLineOn, 1);
        rdchk(`PIF_OFS_STATUS, `PIF_STATUS_RST);
        rdchk(`PIF_OFS_FILT, `PIF_FILT_RST);
        apb(0, 12'h0FC, 0);
        chk(err, 1);
        apb(1, `PIF_OFS_FILT, 1);
        rdchk(`PIF_OFS_FILT, `PIF_FILT_MIN_MS);
        apb(1, `PIF_OFS_FILT, 32'h3FF);
        rdchk(`PIF_OFS_FILT, `PIF_FILT_MAX_MS);
        apb(1, `PIF_OFS_FILT, 2);
        apb(1, `PIF_OFS_FUNC0, 32'h1A020100);
        for (int i = 0; i < 16; i++)
        begin
            settle(i);
            chk(speedIndex, i);
            rdchk(`PIF_OFS_STATUS, i);
        end
        settle(11'h02F);
        chk({jogSelect, speedIndex}, 5'h10);
        settle(11'h100);
        rdchk(`PIF_OFS_STATUS, 0);
        subBoardFitted <= 1;
        settle(11'h100);
        rdchk(`PIF_OFS_STATUS, 32'h100);
        apb(1, `PIF_OFS_FUNC0, 32'h1B050403);
        for (int i = 0; i < 8; i++)
        begin
            settle(i);
            chk(rampIndex, i);
        end
        settle(0);
        bounce <= 1;
        repeat (40) @(posedge core_clk);
        chk(rampIndex, 0);
        rdchk(`PIF_OFS_STATUS, 0);
        bounce <= 0;
        settle(0);
        chk(rampIndex, 0);
        for (int k = 0; k < 9; k++)
        begin
            apb(1, `PIF_OFS_FUNC0, {26'h06C0804, codes[k]});
            settle(1);
            chk(lvl, expLvl[k]);
            settle(0);
        end
        apb(1, `PIF_OFS_FUNC0, 32'h1B020106);
        settle(1);
        driveStopped <= 0;
        repeat (3) @(posedge core_clk);
        chk(dcBrakeOn, 0);
        driveStopped <= 1;
        apb(1, `PIF_OFS_FUNC0, 32'h1B02010D);
        settle(1);
        settle(0);
        chk(tripCutoff, 1);
        rdchk(`PIF_OFS_FAULT, 1);
        apb(1, `PIF_OFS_FAULT, 1);
        chk(tripCutoff, 0);
        settle(1);
        settle(8);
        chk({faultReset, tripCutoff}, 2'b10);
        settle(0);
        apb(1, `PIF_OFS_FUNC0, 32'h210C1F1E);
        settle(8);
        chk(preExcite, 1);
        settle(11'h005);
        settle(11'h004);
        chk({runFwd, runRev, preExcite}, 3'b100);
        settle(0);
        chk({runFwd, runRev}, 2'b00);
        apb(1, `PIF_OFS_FUNC0, 32'h1B021F1E);
        settle(1);
        chk({runFwd, runRev}, 2'b10);
        settle(3);
        chk({runFwd, runRev}, 2'b00);
        settle(0);
        apb(1, `PIF_OFS_MAXF, 3);
        apb(1, `PIF_OFS_FUNC0, 32'h1B230B0A);
        settle(1);
        chk(upDnFreq, 3);
        settle(2);
        chk(upDnFreq, 0);
        apb(1, `PIF_OFS_CTRL, 4);
        settle(1);
        settle(4);
        chk(upDnFreq, 0);
        settle(0);
        apb(1, `PIF_OFS_CTRL, 2);
        settle(11'h00F);
        chk(interlock, 4'hF);
        chk(upDnFreq, 0);
        apb(1, `PIF_OFS_CTRL, 0);
        settle(0);
        apb(1, `PIF_OFS_FUNC0, 32'h1B020710);
        driveStopped <= 0;
        settle(3);
        chk({openLoop, secondFuncOn}, 2'b01);
        driveStopped <= 1;
        repeat (2) @(posedge core_clk);
        chk(openLoop, 1);
        settle(0);
        settle(11'h010);
        chk(emergencyStop, 1);
        apb(1, `PIF_OFS_FILT, 5);
        chk(err, 1);
        rdchk(`PIF_OFS_FILT, 2);
        report_and_stop();
    end
endmodule // programmable_input_function_decoder_test
